// *** rtl/cdc_pkg.sv ***
// Purpose: Shared constants and carriers for the codec clock/control block
// Assumes: One 125 MHz clock; the input clock of the divider chain is i_clk
// Notes: Time figures are kept in their own unit, cycle counts derived
package cdc_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Timing
  localparam int unsigned CLK_PERIOD_PS = 8000;
  localparam int unsigned POR_PULSE_MIN_US = 1500;
  localparam int unsigned POR_PULSE_MAX_US = 7000;
  // Least time rounds up to whole cycles
  localparam int unsigned POR_PULSE_CYCLES =
    (POR_PULSE_MIN_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned POR_CNT_W = 18;

  ////////////////////////////////////////////////////////////////////////////
  // Divider and gain figures
  localparam logic [4:0] RST_DIV_RATIO = 5'h10;
  localparam logic [1:0] IC0_RST_RATIO = 2'h2;
  localparam logic [6:0] OS_PER_SAMPLE = 7'h7d;
  localparam logic [6:0] FRAC_DEN = 7'h7d;
  localparam logic [6:0] M_CODE0_VALUE = 7'h40;
  localparam logic [5:0] GAIN_STEP_DB = 6'h03;

  ////////////////////////////////////////////////////////////////////////////
  // Control word, modulator and clock layouts
  typedef struct packed {
    logic loopback_select;
    logic [3:0] output_gain_select;
    logic [4:0] sys_clock_divider;
  } cdc_cw0_t;

  typedef struct packed {
    logic internal_clock0_divider;
    logic phase_direction;
    logic [6:0] phase_pulse_count;
    logic [4:0] aux_clock_divider;
  } cdc_cw1_t;

  typedef struct packed {
    logic [5:0] m_code;
    logic sign_neg;
    logic [5:0] n_num;
  } cdc_frac_t;

  typedef struct packed {
    logic highpass_enable_n;
    logic dither_disable;
    logic por_pulse_trigger;
  } cdc_cw3_t;

  typedef struct packed {
    logic dig_mod_bit;
    logic ana_mod_bit;
  } cdc_mod_t;

  typedef struct packed {
    logic internal_clock0_en;
    logic oversample_en;
    logic sample_en;
    logic sys_clock_out;
    logic aux_clock_out;
  } cdc_clk_t;

  ////////////////////////////////////////////////////////////////////////////
  // Values after reset
  localparam cdc_cw0_t CW0_RST = '{1'b0, 4'h0, 5'h00};
  localparam cdc_cw1_t CW1_RST = '{1'b0, 1'b0, 7'h00, 5'h00};
  localparam cdc_frac_t FRAC_RST = '{6'h01, 1'b0, 6'h00};
  localparam cdc_cw3_t CW3_RST = '{1'b0, 1'b0, 1'b0};

endpackage

// *** rtl/cdc_sync2.sv ***
// Purpose: Two flip-flop synchroniser for pin levels
// Assumes: Inputs are slow levels from outside the clock domain
// Notes: First stage is read only by the second stage
module cdc_sync2 #(
  parameter int unsigned W = 1
) (
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic [W-1:0] i_async,
  output logic [W-1:0] o_sync
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } cdc_sync_st_t;

  cdc_sync_st_t q, d;

  always_comb begin
    d = q;
    d.s1 = i_async;
    d.s2 = q.s1;
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      // Pins idle high; starting high avoids a false edge after reset
      q <= '1;
    end else begin
      q <= d;
    end
  end

  assign o_sync = q.s2;

endmodule

// *** rtl/cdc_clkdiv.sv ***
// Purpose: Integer output clock divider, ratio 0 (off) or 1 to 31
// Assumes: i_tick is a one-cycle enable at the source clock rate
// Notes: New ratio is taken at terminal count or on restart; only a restart can cut a pulse short
module cdc_clkdiv (
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic i_tick,
  input wire logic [4:0] i_ratio,
  input wire logic i_restart,
  output logic o_clk
);

  typedef struct packed {
    logic [4:0] cnt;
    logic [4:0] ratio;
    logic clk;
  } cdc_div_st_t;

  cdc_div_st_t q, d;

  always_comb begin
    d = q;
    if (i_restart) begin
      d.cnt = 5'h00;
      d.ratio = i_ratio;
      d.clk = 1'b0;
    end else if (i_tick) begin
      if (q.cnt == 5'h00) begin
        d.ratio = i_ratio;
        d.cnt = (i_ratio == 5'h00) ? 5'h00 : i_ratio - 5'h01;
      end else begin
        d.cnt = q.cnt - 5'h01;
      end
      // Zero ratio parks the output low; otherwise high for upper half
      if (d.ratio == 5'h00) begin
        d.clk = 1'b0;
      end else begin
        d.clk = (d.cnt >= (d.ratio >> 1));
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign o_clk = q.clk;

endmodule

// *** rtl/cdc_top.sv ***
// Purpose: Codec clock generation, phase adjust, reset and misc control
// Assumes: i_clk stands for the selected input clock of the divider chain
// Notes: Derived clocks are one-cycle enables; output clocks are levels

module cdc_top #(
  parameter int unsigned P_POR_CYCLES = cdc_pkg::POR_PULSE_CYCLES
) (
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic i_reset_pin_n,
  input wire logic i_osc_enable_pin,
  input wire logic i_por_timing_cap_pin,
  input wire logic i_cw0_wr,
  input wire cdc_pkg::cdc_cw0_t i_cw0,
  input wire logic i_cw1_wr,
  input wire cdc_pkg::cdc_cw1_t i_cw1,
  input wire logic i_frac_wr,
  input wire cdc_pkg::cdc_frac_t i_frac,
  input wire logic i_cw3_wr,
  input wire cdc_pkg::cdc_cw3_t i_cw3,
  input wire cdc_pkg::cdc_mod_t i_mod,
  output logic o_osc_power_en,
  output logic o_ext_clk_select,
  output logic o_internal_reset,
  output logic o_por_out_n,
  output cdc_pkg::cdc_clk_t o_clocks,
  output logic o_sinc_in_bit,
  output logic o_demod_in_bit,
  output logic o_hpf_bypass,
  output logic o_dither_en,
  output logic o_loopback,
  output logic [5:0] o_gain_atten_db
);
  import cdc_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // State

  typedef struct packed {
    cdc_cw0_t cw0;
    cdc_cw1_t cw1;
    cdc_cw3_t cw3;
    cdc_frac_t frac_pend;
    cdc_frac_t frac_act;
    logic [POR_CNT_W-1:0] por_cnt;
    logic rst_pin_prev;
    logic [1:0] ic_cnt;
    logic [6:0] burst_left;
    logic burst_adv;
    logic [6:0] os_cnt;
    logic [6:0] os_idx;
    logic [6:0] acc;
    logic internal_clock0_en;
    logic os_en;
    logic smp_en;
    logic int_rst;
    logic por_out_n;
    logic osc_en;
    logic sinc_bit;
    logic demod_bit;
    logic [5:0] atten;
  } cdc_top_st_t;

  localparam logic [POR_CNT_W-1:0] POR_LOAD = POR_CNT_W'(P_POR_CYCLES);

  localparam cdc_top_st_t TOP_RST = '{
    cw0: CW0_RST,
    cw1: CW1_RST,
    cw3: CW3_RST,
    frac_pend: FRAC_RST,
    frac_act: FRAC_RST,
    por_cnt: POR_LOAD,
    rst_pin_prev: 1'b1,
    ic_cnt: 2'h0,
    burst_left: 7'h00,
    burst_adv: 1'b0,
    os_cnt: 7'h00,
    os_idx: 7'h00,
    acc: 7'h00,
    internal_clock0_en: 1'b0,
    os_en: 1'b0,
    smp_en: 1'b0,
    int_rst: 1'b1,
    por_out_n: 1'b0,
    osc_en: 1'b1,
    sinc_bit: 1'b0,
    demod_bit: 1'b0,
    atten: 6'h00
  };

  cdc_top_st_t q, d;

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers

  logic [2:0] pin_sync;
  logic rst_pin_n_s;
  logic osc_pin_s;
  logic cap_pin_s;

  cdc_sync2 #(
    .W(3)
  ) u_pin_sync (
    .i_clk(i_clk),
    .i_reset_n(i_reset_n),
    .i_async({i_reset_pin_n, i_osc_enable_pin, i_por_timing_cap_pin}),
    .o_sync(pin_sync)
  );

  assign rst_pin_n_s = pin_sync[2];
  assign osc_pin_s = pin_sync[1];
  assign cap_pin_s = pin_sync[0];

  ////////////////////////////////////////////////////////////////////////////
  // Combinational helpers

  logic rst_low;
  logic rst_rise;
  logic por_active;
  logic [1:0] ic_base;
  logic [1:0] ic_eff;
  cdc_frac_t nf;
  logic [6:0] m_val;
  logic [6:0] m_alt;
  logic [7:0] acc_sum;
  logic long_per;
  logic [6:0] per_len;
  logic last_os;
  logic [4:0] sys_ratio;
  logic [4:0] aux_ratio;

  always_comb begin
    rst_low = !rst_pin_n_s;
    // Divider restart on release of the reset pin
    rst_rise = rst_pin_n_s && !q.rst_pin_prev;
    // Inverting cap buffer: pin still below threshold means pulse active
    por_active = (q.por_cnt != '0) || !cap_pin_s;

    // Internal clock0 base ratio, encoding 0 is divide-by-1
    if (rst_low) begin
      ic_base = IC0_RST_RATIO;
    end else begin
      ic_base = q.cw1.internal_clock0_divider ? 2'h2 : 2'h1;
    end
    ic_eff = ic_base;
    if (q.burst_left != 7'h00) begin
      if (q.burst_adv) begin
        // Divide-by-1 cannot advance; it stays at 1
        ic_eff = (ic_base > 2'h1) ? ic_base - 2'h1 : ic_base;
      end else begin
        ic_eff = ic_base + 2'h1;
      end
    end

    // Fractional settings change only at a sample boundary
    last_os = (q.os_idx == OS_PER_SAMPLE - 7'h01);
    nf = last_os ? q.frac_pend : q.frac_act;
    m_val = (nf.m_code == 6'h00) ? M_CODE0_VALUE : {1'b0, nf.m_code};
    m_alt = nf.sign_neg ? m_val - 7'h01 : m_val + 7'h01;
    // Spread N long/short periods evenly over 125 oversample periods
    acc_sum = (last_os ? 8'h00 : {1'b0, q.acc}) + {2'b00, nf.n_num};
    long_per = (acc_sum >= {1'b0, FRAC_DEN});
    per_len = long_per ? m_alt : m_val;

    sys_ratio = rst_low ? RST_DIV_RATIO : q.cw0.sys_clock_divider;
    aux_ratio = rst_low ? RST_DIV_RATIO : q.cw1.aux_clock_divider;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    d = q;
    d.rst_pin_prev = rst_pin_n_s;

    // Power-on pulse element and combined reset
    if (q.por_cnt != '0) begin
      d.por_cnt = q.por_cnt - POR_CNT_W'(1);
    end
    if (!q.int_rst && i_cw3_wr && i_cw3.por_pulse_trigger) begin
      d.por_cnt = POR_LOAD;
    end
    d.int_rst = por_active || rst_low;
    d.por_out_n = !por_active;
    d.osc_en = osc_pin_s;

    // Control words; held at reset values during internal reset
    if (q.int_rst) begin
      d.cw0 = CW0_RST;
      d.cw1 = CW1_RST;
      d.cw3 = CW3_RST;
      d.frac_pend = FRAC_RST;
    end else begin
      if (i_cw0_wr) begin
        d.cw0 = i_cw0;
      end
      if (i_cw1_wr) begin
        d.cw1 = i_cw1;
      end
      if (i_cw3_wr) begin
        d.cw3 = i_cw3;
        d.cw3.por_pulse_trigger = 1'b0;
      end
      if (i_frac_wr) begin
        d.frac_pend = i_frac;
      end
    end

    // Internal clock0 divider with phase burst
    d.internal_clock0_en = 1'b0;
    if (rst_rise) begin
      d.ic_cnt = 2'h0;
      d.burst_left = 7'h00;
    end else if (q.ic_cnt == 2'h0) begin
      d.internal_clock0_en = 1'b1;
      d.ic_cnt = ic_eff - 2'h1;
      if (q.burst_left != 7'h00) begin
        d.burst_left = q.burst_left - 7'h01;
      end
    end else begin
      d.ic_cnt = q.ic_cnt - 2'h1;
    end
    // Each write with a nonzero count starts a fresh burst
    if (!q.int_rst && i_cw1_wr && i_cw1.phase_pulse_count != 7'h00) begin
      d.burst_left = i_cw1.phase_pulse_count;
      d.burst_adv = i_cw1.phase_direction;
    end

    // Fractional oversample divider and fixed sample divider
    d.os_en = 1'b0;
    d.smp_en = 1'b0;
    if (q.internal_clock0_en) begin
      if (q.os_cnt == 7'h00) begin
        d.os_en = 1'b1;
        d.os_cnt = per_len - 7'h01;
        d.acc = long_per ? 7'(acc_sum - {1'b0, FRAC_DEN}) : acc_sum[6:0];
        if (last_os) begin
          // Whole sample spans exactly 125*M + S*N internal clocks
          d.smp_en = 1'b1;
          d.os_idx = 7'h00;
          d.frac_act = q.frac_pend;
        end else begin
          d.os_idx = q.os_idx + 7'h01;
        end
      end else begin
        d.os_cnt = q.os_cnt - 7'h01;
      end
    end

    // Loopback routing of the single-bit modulator streams
    if (q.cw0.loopback_select) begin
      d.sinc_bit = i_mod.dig_mod_bit;
      d.demod_bit = i_mod.ana_mod_bit;
    end else begin
      d.sinc_bit = i_mod.ana_mod_bit;
      d.demod_bit = i_mod.dig_mod_bit;
    end

    // Attenuation in dB, code times the step
    d.atten = 6'({2'b00, q.cw0.output_gain_select} * GAIN_STEP_DB);
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      q <= TOP_RST;
    end else begin
      q <= d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Output clock dividers

  logic sys_clk;
  logic aux_clk;

  // System clock runs from the input clock, every cycle
  cdc_clkdiv u_sys_div (
    .i_clk(i_clk),
    .i_reset_n(i_reset_n),
    .i_tick(1'b1),
    .i_ratio(sys_ratio),
    .i_restart(rst_rise),
    .o_clk(sys_clk)
  );

  // Aux clock follows internal clock0, so bursts move it as well
  cdc_clkdiv u_aux_div (
    .i_clk(i_clk),
    .i_reset_n(i_reset_n),
    .i_tick(q.internal_clock0_en),
    .i_ratio(aux_ratio),
    .i_restart(rst_rise),
    .o_clk(aux_clk)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  always_comb begin
    o_clocks.internal_clock0_en = q.internal_clock0_en;
    o_clocks.oversample_en = q.os_en;
    o_clocks.sample_en = q.smp_en;
    o_clocks.sys_clock_out = sys_clk;
    o_clocks.aux_clock_out = aux_clk;
  end

  assign o_osc_power_en = q.osc_en;
  assign o_ext_clk_select = !q.osc_en;
  assign o_internal_reset = q.int_rst;
  assign o_por_out_n = q.por_out_n;
  assign o_sinc_in_bit = q.sinc_bit;
  assign o_demod_in_bit = q.demod_bit;
  // One bit bypasses both A/D and D/A high-pass stages
  assign o_hpf_bypass = q.cw3.highpass_enable_n;
  assign o_dither_en = !q.cw3.dither_disable;
  assign o_loopback = q.cw0.loopback_select;
  assign o_gain_atten_db = q.atten;

endmodule

// *** dv/cdc_checker.sv ***
// Purpose: Port-level assertions for the codec clock and control block
// Assumes: One clock domain; the bench keeps writes one cycle apart
// Notes: Bound into cdc_top by the statement after the module
module cdc_checker #(
  parameter int unsigned P_POR_CYCLES = 20
) (
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic i_reset_pin_n,
  input wire logic i_cw0_wr,
  input wire cdc_pkg::cdc_cw0_t i_cw0,
  input wire logic i_cw3_wr,
  input wire cdc_pkg::cdc_cw3_t i_cw3,
  input wire cdc_pkg::cdc_mod_t i_mod,
  input wire logic o_osc_power_en,
  input wire logic o_ext_clk_select,
  input wire logic o_internal_reset,
  input wire logic o_por_out_n,
  input wire cdc_pkg::cdc_clk_t o_clocks,
  input wire logic o_sinc_in_bit,
  input wire logic o_demod_in_bit,
  input wire logic o_hpf_bypass,
  input wire logic o_dither_en,
  input wire logic o_loopback,
  input wire logic [5:0] o_gain_atten_db
);
  timeunit 1ns;
  timeprecision 1ps;
  import cdc_pkg::*;
  logic [17:0] low_q, low_d;
  logic [7:0] os_q, os_d;
  // The oversample chain runs on through internal reset,
  // so only a sample clears the count
  always_comb begin
    low_d = o_por_out_n ? 18'h0 : low_q + 18'h1;
    os_d = o_clocks.sample_en ? 8'h00 :
      os_q + {7'h0, o_clocks.oversample_en};
  end
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      low_q <= '0;
      os_q <= '0;
    end else begin
      low_q <= low_d;
      os_q <= os_d;
    end
  end
  //////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);
  sequence s_cw0_taken;
    i_cw0_wr && !o_internal_reset ##1 !i_cw0_wr;
  endsequence
  sequence s_cw3_taken;
    i_cw3_wr && !o_internal_reset && !i_cw3.por_pulse_trigger ##1 !i_cw3_wr;
  endsequence
  AST_EXT_SELECT: assert property (o_ext_clk_select == !o_osc_power_en)
    else $error("clock source select is not the inverse of osc power");
  AST_POR_RESETS: assert property (!o_por_out_n |-> ##[0:1]
    (o_internal_reset || $past(o_internal_reset)))
    else $error("power-on pulse without internal reset");
  AST_PIN_RESET: assert property (!i_reset_pin_n [*5] |-> o_internal_reset)
    else $error("reset pin low without internal reset");
  AST_TRIGGER_POR: assert property (i_cw3_wr && i_cw3.por_pulse_trigger &&
    !o_internal_reset |-> ##[1:3] !o_por_out_n)
    else $error("trigger write gave no power-on pulse");
  AST_POR_LENGTH: assert property ($rose(o_por_out_n) |->
    low_q >= P_POR_CYCLES - 1)
    else $error("power-on pulse too short");
  AST_LOOP_SELECT: assert property (s_cw0_taken |->
    o_loopback == $past(i_cw0.loopback_select))
    else $error("loopback select not applied");
  AST_GAIN: assert property (s_cw0_taken |=>
    o_gain_atten_db == GAIN_STEP_DB * $past(i_cw0.output_gain_select, 2))
    else $error("attenuation not three times the gain field");
  AST_CW3_FIELDS: assert property (s_cw3_taken |=>
    o_hpf_bypass == $past(i_cw3.highpass_enable_n, 2) &&
    o_dither_en == !$past(i_cw3.dither_disable, 2))
    else $error("high-pass or dither control not applied");
  AST_ROUTING: assert property ($past(i_reset_n, 2) &&
    $past(i_mod) == $past(i_mod, 2) && $past(o_loopback) ==
    $past(o_loopback, 2) |-> o_sinc_in_bit == ($past(o_loopback) ?
    $past(i_mod.dig_mod_bit) : $past(i_mod.ana_mod_bit)) &&
    o_demod_in_bit == ($past(o_loopback) ? $past(i_mod.ana_mod_bit) :
    $past(i_mod.dig_mod_bit)))
    else $error("modulator bits routed wrongly");
  AST_IC0_FORCED: assert property (!i_reset_pin_n [*6] ##0
    o_clocks.internal_clock0_en |=> !o_clocks.internal_clock0_en)
    else $error("internal clock0 not halved under reset pin");
  AST_OS_PER_SAMPLE: assert property (o_clocks.sample_en |->
    os_q == 8'h7c)
    else $error("sample not on the 125th oversample tick");
  AST_OS_ON_IC0: assert property (o_clocks.oversample_en |->
    $past(o_clocks.internal_clock0_en))
    else $error("oversample tick without an internal clock0 tick");
endmodule

bind cdc_top cdc_checker #(.P_POR_CYCLES(P_POR_CYCLES)) i_cdc_checker (
  .i_clk, .i_reset_n, .i_reset_pin_n, .i_cw0_wr, .i_cw0, .i_cw3_wr,
  .i_cw3, .i_mod, .o_osc_power_en, .o_ext_clk_select, .o_internal_reset,
  .o_por_out_n, .o_clocks, .o_sinc_in_bit, .o_demod_in_bit, .o_hpf_bypass,
  .o_dither_en, .o_loopback, .o_gain_atten_db);

// *** dv/cdc_host_model.sv ***
// Purpose: Host side that writes the control words
// Assumes: Writes land only once internal reset has ended
// Notes: One-cycle strobes; no handshake exists
module cdc_host_model (
  input wire logic i_clk,
  input wire logic i_internal_reset,
  output logic o_cw0_wr,
  output cdc_pkg::cdc_cw0_t o_cw0,
  output logic o_cw1_wr,
  output cdc_pkg::cdc_cw1_t o_cw1,
  output logic o_frac_wr,
  output cdc_pkg::cdc_frac_t o_frac,
  output logic o_cw3_wr,
  output cdc_pkg::cdc_cw3_t o_cw3
);
  timeunit 1ns;
  timeprecision 1ps;
  import cdc_pkg::*;
  initial begin
    {o_cw0_wr, o_cw1_wr, o_frac_wr, o_cw3_wr} = 4'h0;
    o_cw0 = CW0_RST;
    o_cw1 = CW1_RST;
    o_frac = FRAC_RST;
    o_cw3 = CW3_RST;
  end
  // A write during internal reset is dropped silently, so wait it out
  task automatic wt();
    @(posedge i_clk);
    #1;
    while (i_internal_reset !== 1'b0) begin
      @(posedge i_clk);
      #1;
    end
  endtask
  task automatic w0(input cdc_cw0_t v);
    wt();
    o_cw0 = v;
    o_cw0_wr = 1'b1;
    @(posedge i_clk);
    #1 o_cw0_wr = 1'b0;
  endtask
  task automatic w1(input cdc_cw1_t v);
    wt();
    o_cw1 = v;
    o_cw1_wr = 1'b1;
    @(posedge i_clk);
    #1 o_cw1_wr = 1'b0;
  endtask
  task automatic wf(input cdc_frac_t v);
    wt();
    o_frac = v;
    o_frac_wr = 1'b1;
    @(posedge i_clk);
    #1 o_frac_wr = 1'b0;
  endtask
  task automatic w3(input cdc_cw3_t v);
    wt();
    o_cw3 = v;
    o_cw3_wr = 1'b1;
    @(posedge i_clk);
    #1 o_cw3_wr = 1'b0;
  endtask
endmodule

// *** dv/codec_clock_divider_control_tb.sv ***
// Purpose: Self-checking bench for the codec clock and control block
// Assumes: Power-on count cut to 20 cycles
// Notes: Outputs are sampled at the falling edge, where they are settled
module codec_clock_divider_control_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import cdc_pkg::*;
  localparam int PC = 20;
  typedef struct packed {
    logic lb;
    logic [3:0] gain;
    logic [4:0] sys;
    logic [4:0] aux;
    logic hpf;
    logic dis;
    logic [1:0] md;
  } cdc_row_t;
  logic i_clk = 1'b0;
  logic i_reset_n = 1'b0;
  logic i_reset_pin_n = 1'b1;
  logic i_osc_enable_pin = 1'b1;
  logic i_por_timing_cap_pin = 1'b1;
  cdc_mod_t i_mod = 2'h0;
  logic i_cw0_wr, i_cw1_wr, i_frac_wr, i_cw3_wr;
  cdc_cw0_t i_cw0;
  cdc_cw1_t i_cw1;
  cdc_frac_t i_frac;
  cdc_cw3_t i_cw3;
  logic o_osc_power_en, o_ext_clk_select, o_internal_reset, o_por_out_n;
  cdc_clk_t o_clocks;
  logic o_sinc_in_bit, o_demod_in_bit, o_hpf_bypass, o_dither_en;
  logic o_loopback;
  logic [5:0] o_gain_atten_db;
  int err_total = 0;
  int tests_run = 0;
  cdc_row_t rows [4] = '{'{1'b0, 4'h0, 5'h02, 5'h03, 1'b0, 1'b0, 2'h2},
    '{1'b1, 4'hf, 5'h1f, 5'h10, 1'b1, 1'b1, 2'h2},
    '{1'b0, 4'h7, 5'h03, 5'h1f, 1'b1, 1'b0, 2'h1},
    '{1'b1, 4'h1, 5'h10, 5'h02, 1'b0, 1'b1, 2'h1}};
  // div, direction, count, base gap, burst gap
  int ph [5][5] = '{'{1, 1, 7, 2, 1}, '{1, 0, 127, 2, 3},
    '{0, 0, 5, 1, 2}, '{0, 1, 5, 1, 1}, '{1, 0, 0, 2, 2}};
  // m code, sign, numerator, clocks per sample
  int fr [4][4] = '{'{3, 0, 0, 375}, '{2, 0, 10, 260},
    '{3, 1, 62, 313}, '{1, 0, 0, 125}};
  always #4 i_clk = ~i_clk;
  cdc_top #(.P_POR_CYCLES(PC)) i_cdc_top (.i_clk, .i_reset_n,
    .i_reset_pin_n, .i_osc_enable_pin, .i_por_timing_cap_pin, .i_cw0_wr,
    .i_cw0, .i_cw1_wr, .i_cw1, .i_frac_wr, .i_frac, .i_cw3_wr, .i_cw3,
    .i_mod, .o_osc_power_en, .o_ext_clk_select, .o_internal_reset,
    .o_por_out_n, .o_clocks, .o_sinc_in_bit, .o_demod_in_bit,
    .o_hpf_bypass, .o_dither_en, .o_loopback, .o_gain_atten_db);
  cdc_host_model i_cdc_host_model (.i_clk,
    .i_internal_reset(o_internal_reset), .o_cw0_wr(i_cw0_wr),
    .o_cw0(i_cw0), .o_cw1_wr(i_cw1_wr), .o_cw1(i_cw1),
    .o_frac_wr(i_frac_wr), .o_frac(i_frac), .o_cw3_wr(i_cw3_wr),
    .o_cw3(i_cw3));
  //////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_total++;
      $display("FAIL %0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic summarize();
    if (err_total == 0 && tests_run > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  function automatic logic pick(input int s);
    case (s)
      0: pick = o_clocks.internal_clock0_en;
      1: pick = o_clocks.sample_en;
      2: pick = o_clocks.sys_clock_out;
      4: pick = o_clocks.oversample_en;
      default: pick = o_clocks.aux_clock_out;
    endcase
  endfunction
  // Pulses count to the next pulse, level clocks to the next rise
  task automatic gap(input int s, output int n);
    logic p, c, d;
    p = 1'b1;
    n = 0;
    do begin
      @(negedge i_clk);
      n++;
      c = pick(s);
      d = c === 1'b1 && (s < 2 || s > 3 || p === 1'b0);
      p = c;
    end while (!d && n < 20000);
  endtask
  // Two gaps dropped: the first straddles the ratio change
  task automatic per(input int s, output int n);
    gap(s, n);
    gap(s, n);
    gap(s, n);
  endtask
  //////////////////////////////////////////////////////////////////////////
  initial begin
    #320000;
    err_total++;
    summarize();
  end
  initial begin
    int n, nm, nb;
    logic [1:0] v;
    cdc_row_t r;
    @(negedge i_clk);
    chk({o_por_out_n, o_internal_reset}, 2'h1);
    @(posedge i_clk);
    #1 i_reset_n = 1'b1;
    repeat (PC - 3) @(negedge i_clk);
    chk(o_por_out_n, 1'b0);
    repeat (8) @(negedge i_clk);
    chk({o_por_out_n, o_internal_reset}, 2'h2);
    foreach (rows[k]) begin
      r = rows[k];
      i_cdc_host_model.w0(cdc_cw0_t'{r.lb, r.gain, r.sys});
      i_cdc_host_model.w1(cdc_cw1_t'{1'b0, 1'b0, 7'h00, r.aux});
      i_cdc_host_model.w3(cdc_cw3_t'{r.hpf, r.dis, 1'b0});
      i_mod = r.md;
      repeat (3) @(negedge i_clk);
      chk(o_loopback, r.lb);
      chk(o_sinc_in_bit, r.lb ? r.md[1] : r.md[0]);
      chk(o_demod_in_bit, r.lb ? r.md[0] : r.md[1]);
      chk(o_hpf_bypass, r.hpf);
      chk(o_dither_en, !r.dis);
      chk(o_gain_atten_db, 3 * r.gain);
      per(2, n);
      chk(n, r.sys);
      per(3, n);
      chk(n, r.aux);
    end
    i_cdc_host_model.w0(cdc_cw0_t'{1'b0, 4'h0, 5'h00});
    i_cdc_host_model.w1(cdc_cw1_t'{1'b0, 1'b0, 7'h00, 5'h00});
    repeat (40) @(negedge i_clk);
    v = 2'h0;
    repeat (40) begin
      @(negedge i_clk);
      v = v | {o_clocks.sys_clock_out, o_clocks.aux_clock_out};
    end
    chk(v, 2'h0);
    // Advance at divide-by-1 is the refused case and must stay at one
    foreach (ph[k]) begin
      i_cdc_host_model.w1(cdc_cw1_t'{1'(ph[k][0]), 1'b0, 7'h00, 5'h00});
      repeat (8) @(negedge i_clk);
      i_cdc_host_model.w1(cdc_cw1_t'{1'(ph[k][0]), 1'(ph[k][1]),
        7'(ph[k][2]), 5'h00});
      nm = 0;
      nb = 0;
      gap(0, n);
      repeat (140) begin
        gap(0, n);
        nm += int'(n == ph[k][4]);
        nb += int'(n != ph[k][4] && n != ph[k][3]);
      end
      chk(nb, 0);
      if (ph[k][3] != ph[k][4]) begin
        chk(nm <= ph[k][2] && nm + 2 >= ph[k][2], 1'b1);
      end
    end
    i_cdc_host_model.w1(cdc_cw1_t'{1'b0, 1'b0, 7'h00, 5'h00});
    foreach (fr[k]) begin
      i_cdc_host_model.wf(cdc_frac_t'{6'(fr[k][0]), 1'(fr[k][1]),
        6'(fr[k][2])});
      per(1, n);
      chk(n, fr[k][3]);
      gap(1, n);
      chk(n, fr[k][3]);
      if (fr[k][2] == 0) begin
        gap(4, n);
        gap(4, n);
        chk(n, fr[k][0]);
      end
    end
    i_cdc_host_model.w0(cdc_cw0_t'{1'b1, 4'h5, 5'h00});
    i_cdc_host_model.w3(cdc_cw3_t'{1'b0, 1'b0, 1'b1});
    repeat (4) @(negedge i_clk);
    chk({o_por_out_n, o_internal_reset}, 2'h1);
    n = 0;
    while (o_por_out_n !== 1'b1 && n < 999) begin
      @(negedge i_clk);
      n++;
    end
    chk(n + 4 >= PC && n <= PC, 1'b1);
    chk(o_gain_atten_db, 6'h00);
    @(posedge i_clk);
    #1 i_por_timing_cap_pin = 1'b0;
    repeat (30) @(negedge i_clk);
    chk({o_por_out_n, o_internal_reset}, 2'h1);
    @(posedge i_clk);
    #1 i_por_timing_cap_pin = 1'b1;
    repeat (8) @(negedge i_clk);
    chk({o_por_out_n, o_internal_reset}, 2'h2);
    @(posedge i_clk);
    #1 i_reset_pin_n = 1'b0;
    repeat (8) @(negedge i_clk);
    chk({o_por_out_n, o_internal_reset}, 2'h3);
    per(2, n);
    chk(n, 16);
    per(3, n);
    chk(n, 32);
    gap(0, n);
    gap(0, n);
    chk(n, 2);
    @(posedge i_clk);
    #1 i_reset_pin_n = 1'b1;
    repeat (8) @(negedge i_clk);
    chk(o_internal_reset, 1'b0);
    for (int b = 0; b < 2; b++) begin
      @(posedge i_clk);
      #1 i_osc_enable_pin = b[0];
      repeat (4) @(negedge i_clk);
      chk({o_osc_power_en, o_ext_clk_select}, b ? 2'h2 : 2'h1);
    end
    summarize();
  end
endmodule
